// File: hmi_regs.vh
// register map, field positions, reset values and timing counts of the host mode block
`ifndef HMI_REGS_VH
`define HMI_REGS_VH

// host address map (byte addresses on the host pins)
`define HMI_ADDR_W        17
`define HMI_BASE_ADDR     17'h08000
`define HMI_SPACE_BYTES   17'h00400
`define HMI_MODE_ADDR     17'h08000
`define HMI_PTR_ADDR      17'h08002
`define HMI_WIN_ADDR      17'h08004

// reset values
`define HMI_MODE_RST      8'h00
`define HMI_PTR_RST       16'h0000
`define HMI_WIN_RST       16'h0000

// low mode byte fields
`define HMI_BIT_SRST      7
`define HMI_BIT_MTEST     5
`define HMI_BIT_ECHO_BLK  4
`define HMI_BIT_PPPOE     3
`define HMI_BIT_BSWAP     2
`define HMI_BIT_STYLE     0
`define HMI_MODE_WMASK    8'hBD

// socket fifo port decode inside the internal register space
`define HMI_OFS_W         10
`define HMI_SOCK_BASE     10'h200
`define HMI_TX_FIFO_OFS   6'h2E
`define HMI_RX_FIFO_OFS   6'h30

// echo handling
`define HMI_ICMP_PROTO    8'h01
`define HMI_ECHO_MAX      16'h0077

// software reset duration
`define HMI_CLK_NS        8
`define HMI_SRST_NS       64
`define HMI_SRST_CYC      ((`HMI_SRST_NS + `HMI_CLK_NS - 1) / `HMI_CLK_NS)

`endif

// File: hmi_lane_swap.v
// byte lane exchanger for a 16-bit host word
`timescale 1ns/1ps
module hmi_lane_swap (
	input  wire [15:0] data_in,   // word in register order
	input  wire        swap_in,   // high to exchange the two bytes
	output wire [15:0] data_out   // word after optional exchange
);
	// plain mux, no state: swap setting acts from the next access on
	assign data_out = swap_in ? {data_in[7:0], data_in[15:8]} : data_in;
endmodule

// File: hmi_echo_gate.v
// decides whether a received echo request gets an automatic reply
`timescale 1ns/1ps
`include "hmi_regs.vh"
module hmi_echo_gate (
	input  wire        ref_clk_in,      // system clock
	input  wire        arst_n_in,       // async reset, active low
	input  wire        echo_req_in,     // one-cycle pulse per echo request
	input  wire [15:0] echo_len_in,     // request payload length in bytes
	input  wire        block_in,        // echo reply blocking setting
	input  wire [7:0]  raw_ip_in,       // per socket: opened in raw ip mode
	input  wire [63:0] proto_in,        // per socket protocol number, socket 0 low
	output reg         reply_go_out,    // pulse: send automatic reply
	output reg         reply_drop_out   // pulse: request left unanswered
);
	reg     icmp_sock;
	reg     allow;
	integer i;

	// any raw socket bound to icmp takes the request over from the hardware
	always @* begin
		icmp_sock = 1'b0;
		for (i = 0; i < 8; i = i + 1) begin
			if (raw_ip_in[i] && (proto_in[8*i +: 8] == `HMI_ICMP_PROTO))
				icmp_sock = 1'b1;
		end
		allow = !block_in && !icmp_sock && (echo_len_in <= `HMI_ECHO_MAX);
	end

	// registered decision, one cycle after the request
	always @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reply_go_out   <= 1'b0;
			reply_drop_out <= 1'b0;
		end else begin
			reply_go_out   <= echo_req_in && allow;
			reply_drop_out <= echo_req_in && !allow;
		end
	end
endmodule

// File: hmi_host_port.v
// host mode control and indirect register access port
`timescale 1ns/1ps
`include "hmi_regs.vh"
// Notes on behaviour
// - writing one to mode bit 7 resets the device; bit clears after reset ends.
// - without memory test, tx fifo port is write-only and rx fifo port read-only.
// - with memory test, both fifo ports accept host reads and writes.
// - echo block bit set suppresses automatic echo replies.
// - raw ip socket with protocol one also suppresses automatic echo replies.
// - automatic echo reply only for payloads of at most 119 bytes.
// - bus swap exchanges high and low bytes of every register, fifo ports too.
// - fifo swap affects only the socket fifo ports.
// - bus swap acts only on a 16-bit bus, ignored on 8-bit.
// - mode bit 0 selects direct (0) or indirect (1) addressing.
// - indirect mode decodes only mode, pointer and window; the rest via window.
// - pointer bit 0 is ignored; targets are always word aligned.
// - pointer high byte is target offset upper byte, low byte the lower.
// - window accesses hit the pointed register; high byte to upper byte.
// - pointer register at 0x08002, reset 0x0000.
// - window register at 0x08004, reset 0x0000.
// - bus width latched from strap at reset; read-only afterwards.
// - fifo swap exchanges fifo port bytes for little-endian hosts.
module hmi_host_port (
	input  wire        ref_clk_in,                  // system clock, 125 MHz
	input  wire        arst_n_in,                   // async reset, active low
	input  wire        bus16_strap_in,              // bus width strap pin
	input  wire        host_cs_n_in,                // host chip select, active low
	input  wire        host_rd_n_in,                // host read strobe, active low
	input  wire        host_wr_n_in,                // host write strobe, active low
	input  wire [16:0] host_addr_in,                // host byte address
	input  wire [15:0] host_data_in,                // host data pins, input side
	output wire [15:0] host_data_out,               // host data pins, output side
	output wire        host_data_oe_out,            // high while driving data pins
	output wire [9:0]  reg_addr_out,                // internal register offset
	output wire [15:0] reg_wdata_out,               // internal write data
	output wire [1:0]  reg_be_out,                  // byte enables, bit 1 upper byte
	output wire        reg_wr_out,                  // internal write pulse
	output wire        reg_rd_out,                  // internal read pulse
	input  wire [15:0] reg_rdata_in,                // internal read data, same cycle
	input  wire        fifo_byte_swap_in,           // fifo port swap setting
	input  wire        echo_request_in,             // echo request received pulse
	input  wire [15:0] echo_len_in,                 // echo payload length
	input  wire [7:0]  socket_raw_ip_setting_in,    // per socket raw ip mode
	input  wire [63:0] socket_protocol_number_in,   // per socket protocol number
	output wire        echo_reply_go_out,           // send automatic reply pulse
	output wire        echo_reply_drop_out,         // request not answered pulse
	output wire        soft_reset_out,              // device reset in progress
	output wire        host_access_style_out,       // 1 indirect addressing
	output wire        buffer_memory_test_out,      // memory test enabled
	output wire        pppoe_enable_out,            // pppoe operation enabled
	output wire        bus_width_select_out         // 1 for a 16-bit data bus
);
	// ************************************************************
	// constants
	// ************************************************************
	localparam K_NONE = 3'h0;
	localparam K_MODE = 3'h1;
	localparam K_PTR  = 3'h2;
	localparam K_WIN  = 3'h3;
	localparam K_EXT  = 3'h4;
	localparam [31:0] SRST_CYC  = `HMI_SRST_CYC;
	localparam [7:0]  SRST_LOAD = SRST_CYC[7:0] - 8'h01;

	// ************************************************************
	// functions
	// ************************************************************
	// host address to access kind; pointer and window only exist in indirect mode
	function [2:0] dec_kind;
		input [16:0] a;
		input        host_access_style;
		reg   [16:0] w;
		begin
			w = {a[16:1], 1'b0};
			if (w == `HMI_MODE_ADDR)
				dec_kind = K_MODE;
			else if (host_access_style && (w == `HMI_PTR_ADDR))
				dec_kind = K_PTR;
			else if (host_access_style && (w == `HMI_WIN_ADDR))
				dec_kind = K_WIN;
			else if (!host_access_style && (w >= `HMI_BASE_ADDR) && (w < `HMI_BASE_ADDR + `HMI_SPACE_BYTES))
				dec_kind = K_EXT;
			else
				dec_kind = K_NONE;
		end
	endfunction

	// target offset: host address in direct mode, pointer in indirect mode
	function [9:0] tgt_ofs;
		input [16:0] a;
		input        host_access_style;
		input [15:0] ptr;
		reg   [16:0] d;
		begin
			d = a - `HMI_BASE_ADDR;
			if (host_access_style)
				tgt_ofs = {ptr[9:1], 1'b0};
			else
				tgt_ofs = {d[9:1], 1'b0};
		end
	endfunction

	// socket fifo port hit, {tx, rx}
	function [1:0] fifo_hit;
		input [9:0] ofs;
		reg   [9:0] rel;
		begin
			rel = ofs - `HMI_SOCK_BASE;
			if (ofs >= `HMI_SOCK_BASE)
				fifo_hit = {rel[5:0] == `HMI_TX_FIFO_OFS, rel[5:0] == `HMI_RX_FIFO_OFS};
			else
				fifo_hit = 2'b00;
		end
	endfunction

	// ************************************************************
	// pin synchronisers and strobe edges
	// ************************************************************
	reg  [2:0]  pin_s1_r;
	reg  [2:0]  pin_s2_r;
	reg  [16:0] addr_s1_r;
	reg  [16:0] addr_s2_r;
	reg  [15:0] data_s1_r;
	reg  [15:0] data_s2_r;
	reg         strap_s1_r;
	reg         strap_s2_r;
	reg         rd_act_q_r;
	reg         wr_act_q_r;
	reg  [16:0] wr_addr_r;
	reg  [15:0] wr_data_r;
	wire        rd_act   = !pin_s2_r[2] && !pin_s2_r[1];
	wire        wr_act   = !pin_s2_r[2] && !pin_s2_r[0];
	wire        rd_start = rd_act && !rd_act_q_r;
	wire        wr_end   = !wr_act && wr_act_q_r;

	// every pin passes two flops; write fields follow the pins while the strobe is low and hold once it rises
	always @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pin_s1_r   <= 3'h7;
			pin_s2_r   <= 3'h7;
			addr_s1_r  <= 17'h00000;
			addr_s2_r  <= 17'h00000;
			data_s1_r  <= 16'h0000;
			data_s2_r  <= 16'h0000;
			strap_s1_r <= 1'b0;
			strap_s2_r <= 1'b0;
			rd_act_q_r <= 1'b0;
			wr_act_q_r <= 1'b0;
			wr_addr_r  <= 17'h00000;
			wr_data_r  <= 16'h0000;
		end else begin
			pin_s1_r   <= {host_cs_n_in, host_rd_n_in, host_wr_n_in};
			pin_s2_r   <= pin_s1_r;
			addr_s1_r  <= host_addr_in;
			addr_s2_r  <= addr_s1_r;
			data_s1_r  <= host_data_in;
			data_s2_r  <= data_s1_r;
			strap_s1_r <= bus16_strap_in;
			strap_s2_r <= strap_s1_r;
			rd_act_q_r <= rd_act;
			wr_act_q_r <= wr_act;
			if (wr_act) begin
				wr_addr_r <= addr_s2_r;
				wr_data_r <= data_s2_r;
			end
		end
	end

	// ************************************************************
	// control state
	// ************************************************************
	reg  [7:0]  mode_low_r;
	reg  [15:0] ptr_r;
	reg  [15:0] win_r;
	reg         bus16_r;
	reg  [1:0]  strap_wait_r;
	reg         srst_busy_r;
	reg  [7:0]  srst_cnt_r;
	wire        style  = mode_low_r[`HMI_BIT_STYLE];
	wire        mtest  = mode_low_r[`HMI_BIT_MTEST];
	wire        bswap  = mode_low_r[`HMI_BIT_BSWAP] && bus16_r;

	// ************************************************************
	// write path decode
	// ************************************************************
	wire [2:0]  wkind  = dec_kind(wr_addr_r, style);
	wire [9:0]  wofs   = tgt_ofs(wr_addr_r, style, ptr_r);
	wire [1:0]  wfifo  = fifo_hit(wofs);
	wire        wtgt   = (wkind == K_WIN) || (wkind == K_EXT);
	wire        wswap  = bswap ^ (wtgt && (|wfifo) && fifo_byte_swap_in);
	wire [15:0] wraw   = bus16_r ? wr_data_r : {wr_data_r[7:0], wr_data_r[7:0]};
	wire [1:0]  wbe_h  = bus16_r ? 2'b11 : (wr_addr_r[0] ? 2'b01 : 2'b10);
	wire [1:0]  wbe    = wswap ? {wbe_h[0], wbe_h[1]} : wbe_h;
	wire [15:0] wword;
	wire        wpermit = !wfifo[0] || mtest;

	hmi_lane_swap u_wswap (
		.data_in  (wraw),
		.swap_in  (wswap),
		.data_out (wword)
	);

	// ************************************************************
	// read path decode
	// ************************************************************
	wire [2:0]  rkind   = dec_kind(addr_s2_r, style);
	wire [9:0]  rofs    = tgt_ofs(addr_s2_r, style, ptr_r);
	wire [1:0]  rfifo   = fifo_hit(rofs);
	wire        rtgt    = (rkind == K_WIN) || (rkind == K_EXT);
	wire        rpermit = !rfifo[1] || mtest;
	reg         rd_pend_r;
	reg  [2:0]  rd_kind_r;
	reg         rd_lo_r;
	reg         rd_swap_r;
	reg  [15:0] rd_word;
	wire [15:0] rd_word_sw;
	reg  [15:0] host_rdata_r;

	hmi_lane_swap u_rswap (
		.data_in  (rd_word),
		.swap_in  (rd_swap_r),
		.data_out (rd_word_sw)
	);

	// internal access outputs; write and read pulses one cycle wide, offset, data and enables held
	reg         reg_wr_r;
	reg         reg_rd_r;
	reg  [9:0]  reg_addr_r;
	reg  [15:0] reg_wdata_r;
	reg  [1:0]  reg_be_r;

	// word seen by the read path once the internal answer is back
	always @* begin
		case (rd_kind_r)
			K_MODE:  rd_word = {bus16_r, 6'h00, fifo_byte_swap_in, mode_low_r};
			K_PTR:   rd_word = ptr_r;
			K_WIN:   rd_word = reg_rd_r ? reg_rdata_in : 16'h0000;
			K_EXT:   rd_word = reg_rd_r ? reg_rdata_in : 16'h0000;
			default: rd_word = 16'h0000;
		endcase
	end

	// ************************************************************
	// register updates, software reset and host accesses
	// ************************************************************
	always @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mode_low_r    <= `HMI_MODE_RST;
			ptr_r         <= `HMI_PTR_RST;
			win_r         <= `HMI_WIN_RST;
			bus16_r       <= 1'b0;
			strap_wait_r  <= 2'b00;
			srst_busy_r   <= 1'b0;
			srst_cnt_r    <= 8'h00;
			reg_wr_r      <= 1'b0;
			reg_rd_r      <= 1'b0;
			reg_addr_r    <= 10'h000;
			reg_wdata_r   <= 16'h0000;
			reg_be_r      <= 2'b00;
			rd_pend_r     <= 1'b0;
			rd_kind_r     <= K_NONE;
			rd_lo_r       <= 1'b0;
			rd_swap_r     <= 1'b0;
			host_rdata_r  <= 16'h0000;
		end else begin
			reg_wr_r  <= 1'b0;
			reg_rd_r  <= 1'b0;
			rd_pend_r <= 1'b0;
			// strap followed until the synchroniser has filled, then frozen;
			// taking it at the first edge would catch the reset value of the flops
			if (strap_wait_r != 2'b11) begin
				bus16_r      <= strap_s2_r;
				strap_wait_r <= strap_wait_r + 2'b01;
			end
			if (srst_busy_r) begin
				// writes are dropped while the device restarts
				if (srst_cnt_r == 8'h00) begin
					srst_busy_r   <= 1'b0;
					mode_low_r    <= `HMI_MODE_RST;
					ptr_r         <= `HMI_PTR_RST;
					win_r         <= `HMI_WIN_RST;
					strap_wait_r  <= 2'b00;
				end else begin
					srst_cnt_r <= srst_cnt_r - 8'h01;
				end
			end else if (wr_end) begin
				case (wkind)
					K_MODE: begin
						if (wbe[0]) begin
							mode_low_r <= wword[7:0] & `HMI_MODE_WMASK;
							if (wword[`HMI_BIT_SRST]) begin
								srst_busy_r <= 1'b1;
								srst_cnt_r  <= SRST_LOAD;
							end
						end
					end
					K_PTR: begin
						if (wbe[1])
							ptr_r[15:8] <= wword[15:8];
						if (wbe[0])
							ptr_r[7:0] <= wword[7:0];
					end
					K_WIN, K_EXT: begin
						if (wkind == K_WIN) begin
							if (wbe[1])
								win_r[15:8] <= wword[15:8];
							if (wbe[0])
								win_r[7:0] <= wword[7:0];
						end
						reg_wr_r    <= wpermit;
						reg_addr_r  <= wofs;
						reg_wdata_r <= wword;
						reg_be_r    <= wbe;
					end
					default: begin
						reg_wr_r <= 1'b0;
					end
				endcase
			end
			// read: issue internal read, answer one cycle later
			if (rd_start && !wr_end) begin
				rd_pend_r  <= 1'b1;
				rd_kind_r  <= rkind;
				rd_lo_r    <= addr_s2_r[0];
				rd_swap_r  <= bswap ^ (rtgt && (|rfifo) && fifo_byte_swap_in);
				reg_rd_r   <= rtgt && rpermit;
				reg_addr_r <= rofs;
				reg_be_r   <= 2'b11;
			end
			if (rd_pend_r) begin
				if (rd_kind_r == K_WIN)
					win_r <= rd_word;
				if (bus16_r)
					host_rdata_r <= rd_word_sw;
				else
					host_rdata_r <= {8'h00, rd_lo_r ? rd_word_sw[7:0] : rd_word_sw[15:8]};
			end
		end
	end

	// ************************************************************
	// echo reply decision
	// ************************************************************
	hmi_echo_gate u_echo (
		.ref_clk_in     (ref_clk_in),
		.arst_n_in      (arst_n_in),
		.echo_req_in    (echo_request_in),
		.echo_len_in    (echo_len_in),
		.block_in       (mode_low_r[`HMI_BIT_ECHO_BLK]),
		.raw_ip_in      (socket_raw_ip_setting_in),
		.proto_in       (socket_protocol_number_in),
		.reply_go_out   (echo_reply_go_out),
		.reply_drop_out (echo_reply_drop_out)
	);

	// ************************************************************
	// outputs
	// ************************************************************
	assign host_data_out          = host_rdata_r;
	assign host_data_oe_out       = rd_act;
	assign reg_addr_out           = reg_addr_r;
	assign reg_wdata_out          = reg_wdata_r;
	assign reg_be_out             = reg_be_r;
	assign reg_wr_out             = reg_wr_r;
	assign reg_rd_out             = reg_rd_r;
	assign soft_reset_out         = srst_busy_r;
	assign host_access_style_out  = style;
	assign buffer_memory_test_out = mtest;
	assign pppoe_enable_out       = mode_low_r[`HMI_BIT_PPPOE];
	assign bus_width_select_out   = bus16_r;
endmodule

// File: hmi_host_monitor.sv
// checker of the host mode port, bound to its top module
`timescale 1ns/1ps
module hmi_host_monitor (
	input wire logic        ref_clk_in,
	input wire logic        arst_n_in,
	input wire logic        host_cs_n_in,
	input wire logic        host_rd_n_in,
	input wire logic        host_data_oe_out,
	input wire logic [9:0]  reg_addr_out,
	input wire logic        reg_wr_out,
	input wire logic        reg_rd_out,
	input wire logic        echo_request_in,
	input wire logic [15:0] echo_len_in,
	input wire logic [7:0]  socket_raw_ip_setting_in,
	input wire logic [63:0] socket_protocol_number_in,
	input wire logic        echo_reply_go_out,
	input wire logic        echo_reply_drop_out,
	input wire logic        soft_reset_out,
	input wire logic        host_access_style_out,
	input wire logic        buffer_memory_test_out,
	input wire logic        pppoe_enable_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);

	// any socket opened raw with the echo protocol number
	logic icmp_any;
	always_comb begin
		icmp_any = 1'b0;
		for (int n = 0; n < 8; n++) begin
			if (socket_raw_ip_setting_in[n] && socket_protocol_number_in[8*n +: 8] == 8'h01)
				icmp_any = 1'b1;
		end
	end

	// ************************
	// assertions
	// ************************
	// ************************
	a_wr_single: assert property (reg_wr_out |=> !reg_wr_out)
		else $error("internal write pulse lasted more than one cycle");
	a_addr_even: assert property ((reg_wr_out || reg_rd_out) |-> !reg_addr_out[0])
		else $error("internal offset not word aligned");
	a_srst_len: assert property ($rose(soft_reset_out) |-> soft_reset_out[*8] ##1 !soft_reset_out)
		else $error("software reset did not last eight cycles");
	a_srst_clear: assert property ($fell(soft_reset_out) |-> ##[0:1]
		!(host_access_style_out || buffer_memory_test_out || pppoe_enable_out))
		else $error("mode bits survived software reset");
	a_echo_one: assert property (echo_request_in |=> echo_reply_go_out ^ echo_reply_drop_out)
		else $error("echo request not answered by exactly one pulse");
	a_echo_quiet: assert property (!echo_request_in |=> !echo_reply_go_out && !echo_reply_drop_out)
		else $error("echo pulse without a request");
	a_echo_long: assert property (echo_request_in && echo_len_in > 16'h0077 |=> echo_reply_drop_out)
		else $error("long echo request was answered");
	a_echo_raw: assert property (echo_request_in && icmp_any |=> echo_reply_drop_out)
		else $error("echo answered while a raw echo socket is open");
	a_rx_nowrite: assert property (reg_wr_out && !buffer_memory_test_out
		|-> !(reg_addr_out[9] && reg_addr_out[5:0] == 6'h30))
		else $error("receive fifo port written outside memory test");
	a_tx_noread: assert property (reg_rd_out && !buffer_memory_test_out
		|-> !(reg_addr_out[9] && reg_addr_out[5:0] == 6'h2E))
		else $error("transmit fifo port read outside memory test");
	a_oe_cause: assert property (host_data_oe_out |-> !$past(host_cs_n_in, 2) && !$past(host_rd_n_in, 2))
		else $error("data pins driven without a host read");

	// main scenarios reached
	c_srst: cover property ($rose(soft_reset_out));
	c_echo_go: cover property (echo_request_in ##1 echo_reply_go_out);
	c_mtest_wr: cover property (reg_wr_out && buffer_memory_test_out);
endmodule

bind hmi_host_port hmi_host_monitor i_mon (
	.ref_clk_in, .arst_n_in, .host_cs_n_in, .host_rd_n_in, .host_data_oe_out,
	.reg_addr_out, .reg_wr_out, .reg_rd_out, .echo_request_in, .echo_len_in,
	.socket_raw_ip_setting_in, .socket_protocol_number_in, .echo_reply_go_out,
	.echo_reply_drop_out, .soft_reset_out, .host_access_style_out,
	.buffer_memory_test_out, .pppoe_enable_out
);

// File: hmi_host_model.sv
// host processor model driving the parallel bus pins of the port
`timescale 1ns/1ps
module hmi_host_model (
	input  wire logic        ref_clk_in,    // system clock
	input  wire logic [15:0] host_pins_in,  // resolved data pins
	output logic             host_cs_n_out, // chip select, active low
	output logic             host_rd_n_out, // read strobe, active low
	output logic             host_wr_n_out, // write strobe, active low
	output logic [16:0]      host_addr_out, // byte address
	output logic [15:0]      host_drv_out   // value the host puts on the pins
);
	// idle bus from time zero
	initial begin
		host_cs_n_out = 1'b1;
		host_rd_n_out = 1'b1;
		host_wr_n_out = 1'b1;
		host_addr_out = 17'h00000;
		host_drv_out  = 16'h0000;
	end

	// one word access; strobe low five cycles and high five, longer than the synchroniser needs
	task access(input logic we, input logic [16:0] a, input logic [15:0] d,
		output logic [15:0] q);
		@(negedge ref_clk_in);
		host_addr_out = a;
		host_drv_out  = d;
		host_cs_n_out = 1'b0;
		host_wr_n_out = !we;
		host_rd_n_out = we;
		repeat (5) @(negedge ref_clk_in);
		q = host_pins_in;
		host_cs_n_out = 1'b1;
		host_wr_n_out = 1'b1;
		host_rd_n_out = 1'b1;
		host_drv_out  = ~d; // released pins must not keep the old value
		repeat (5) @(negedge ref_clk_in);
	endtask
endmodule

// File: testbench.sv
// self-checking bench for the host mode and indirect access port
`timescale 1ns/1ps
`include "hmi_regs.vh"
module testbench;
	// ************************
	// signals
	// ************************
	logic ref_clk_in = 1'b0, arst_n_in = 1'b0, bus16_strap_in = 1'b1;
	logic host_cs_n_in, host_rd_n_in, host_wr_n_in, fifo_byte_swap_in = 1'b0;
	logic [16:0] host_addr_in;
	logic [15:0] host_drv, host_data_in, host_data_out, reg_wdata_out, reg_rdata_in;
	logic [9:0] reg_addr_out;
	logic [1:0] reg_be_out;
	logic host_data_oe_out, reg_wr_out, reg_rd_out, echo_request_in = 1'b0;
	logic [15:0] echo_len_in = 16'h0000;
	logic [7:0] socket_raw_ip_setting_in = 8'h00;
	logic [63:0] socket_protocol_number_in = 64'h0;
	logic echo_reply_go_out, echo_reply_drop_out, soft_reset_out, host_access_style_out;
	logic buffer_memory_test_out, pppoe_enable_out, bus_width_select_out;
	logic [15:0] store [0:511] = '{default: 16'h0000};
	logic [15:0] p, d, q;
	logic blk, icmp, go;
	integer seed, i, n, n_mismatch = 0, checked = 0;

	always #4 ref_clk_in = ~ref_clk_in;
	// the port drives the pins only while it enables them
	assign host_data_in = host_data_oe_out ? host_data_out : host_drv;
	// internal register space behind the port, read data in the same cycle
	assign reg_rdata_in = store[reg_addr_out[9:1]];
	always @(posedge ref_clk_in) begin
		if (reg_wr_out && reg_be_out[1]) store[reg_addr_out[9:1]][15:8] <= reg_wdata_out[15:8];
		if (reg_wr_out && reg_be_out[0]) store[reg_addr_out[9:1]][7:0] <= reg_wdata_out[7:0];
	end

	hmi_host_port i_dut (.ref_clk_in, .arst_n_in, .bus16_strap_in, .host_cs_n_in,
		.host_rd_n_in, .host_wr_n_in, .host_addr_in, .host_data_in, .host_data_out,
		.host_data_oe_out, .reg_addr_out, .reg_wdata_out, .reg_be_out, .reg_wr_out,
		.reg_rd_out, .reg_rdata_in, .fifo_byte_swap_in, .echo_request_in, .echo_len_in,
		.socket_raw_ip_setting_in, .socket_protocol_number_in, .echo_reply_go_out,
		.echo_reply_drop_out, .soft_reset_out, .host_access_style_out,
		.buffer_memory_test_out, .pppoe_enable_out, .bus_width_select_out);
	hmi_host_model i_host (.ref_clk_in, .host_pins_in(host_data_in),
		.host_cs_n_out(host_cs_n_in), .host_rd_n_out(host_rd_n_in),
		.host_wr_n_out(host_wr_n_in), .host_addr_out(host_addr_in), .host_drv_out(host_drv));

	// ************************
	// tasks
	// ************************
	function automatic logic [15:0] sw(input logic [15:0] x);
		return {x[7:0], x[15:8]};
	endfunction
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task hw(input logic [16:0] a, input logic [15:0] v);
		logic [15:0] t;
		i_host.access(1'b1, a, v, t);
	endtask
	task hr(input logic [16:0] a);
		i_host.access(1'b0, a, 16'h0000, q);
	endtask
	task tally_and_finish;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ************************
	// scenarios
	// ************************
	// whole run is about 630 cycles; the limit leaves ample room
	initial begin
		#100000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		seed = 32'hC6C0B5FB;
		repeat (5) @(negedge ref_clk_in);
		arst_n_in = 1'b1;
		repeat (4) @(negedge ref_clk_in);
		hr(`HMI_MODE_ADDR);
		chk("mode_reset", 16'h8000, q);
		chk("bus_width", 16'h0001, {15'h0, bus_width_select_out});
		hw(`HMI_PTR_ADDR, 16'h1234); // direct mode reaches offset 0x002
		chk("direct_ofs", 16'h1234, store[1]);
		hw(`HMI_MODE_ADDR, 16'h0009);
		chk("style", 16'h0001, {15'h0, host_access_style_out});
		chk("pppoe", 16'h0001, {15'h0, pppoe_enable_out});
		hr(`HMI_PTR_ADDR);
		chk("ptr_reset", 16'h0000, q);
		hr(`HMI_WIN_ADDR);
		chk("win_reset", 16'h0000, q);
		hr(17'h08010);
		chk("undecoded", 16'h0000, q);
		// random targets through the window, every pointer written odd
		for (i = 0; i < 6; i++) begin
			p = 16'($random(seed)) & 16'h01FE;
			d = 16'($random(seed));
			hw(`HMI_PTR_ADDR, p | 16'h0001);
			hw(`HMI_WIN_ADDR, d);
			chk("win_wr", d, store[p[9:1]]);
			store[p[9:1]] = ~d;
			hr(`HMI_WIN_ADDR);
			chk("win_rd", ~d, q);
		end
		// bus swap, then bus swap and fifo swap cancelling on a fifo port
		hw(`HMI_MODE_ADDR, 16'h0005);
		hr(`HMI_MODE_ADDR);
		chk("mode_swap", 16'h0580, q);
		hw(`HMI_PTR_ADDR, 16'h4000);
		hw(`HMI_WIN_ADDR, d);
		chk("bswap_wr", sw(d), store[32]);
		fifo_byte_swap_in = 1'b1;
		hw(`HMI_PTR_ADDR, 16'h2E02);
		hw(`HMI_WIN_ADDR, d);
		chk("both_swap", d, store[9'h117]);
		hw(`HMI_MODE_ADDR, 16'h0100); // indirect only, sent swapped
		hw(`HMI_PTR_ADDR, 16'h022E);
		hw(`HMI_WIN_ADDR, d);
		chk("fs_tx_wr", sw(d), store[9'h117]);
		hr(`HMI_WIN_ADDR);
		chk("tx_rd_refused", 16'h0000, q);
		hw(`HMI_PTR_ADDR, 16'h0230);
		hw(`HMI_WIN_ADDR, d);
		chk("rx_wr_refused", 16'h0000, store[9'h118]);
		store[9'h118] = d;
		hr(`HMI_WIN_ADDR);
		chk("fs_rx_rd", sw(d), q);
		// memory test opens both directions on both fifo ports
		hw(`HMI_MODE_ADDR, 16'h0021);
		chk("mtest", 16'h0001, {15'h0, buffer_memory_test_out});
		hw(`HMI_WIN_ADDR, ~d);
		chk("mt_rx_wr", sw(~d), store[9'h118]);
		hw(`HMI_PTR_ADDR, 16'h022E);
		hr(`HMI_WIN_ADDR);
		chk("mt_tx_rd", d, q);
		// software reset closes the memory test
		hw(`HMI_MODE_ADDR, 16'h0080);
		chk("srst_busy", 16'h0001, {15'h0, soft_reset_out});
		for (i = 0; i < 20 && soft_reset_out !== 1'b0; i++) @(negedge ref_clk_in);
		chk("srst_end", 16'h0000, {15'h0, soft_reset_out});
		chk("srst_mtest", 16'h0000, {15'h0, buffer_memory_test_out});
		hr(`HMI_MODE_ADDR);
		chk("srst_mode", 16'h8100, q);
		hw(`HMI_MODE_ADDR, 16'h0001);
		hr(`HMI_PTR_ADDR);
		chk("srst_ptr", 16'h0000, q);
		// echo requests around the length limit, unblocked then blocked
		for (i = 0; i < 24; i++) begin
			if (i == 12)
				hw(`HMI_MODE_ADDR, 16'h0011);
			blk = (i >= 12);
			@(negedge ref_clk_in);
			echo_request_in = 1'b1;
			echo_len_in = 16'h006E + 16'($random(seed) & 32'h0000000F);
			socket_raw_ip_setting_in = 8'($random(seed) & $random(seed) & $random(seed));
			socket_protocol_number_in = {$random(seed), $random(seed)} & 64'h0101010101010101;
			icmp = 1'b0;
			for (n = 0; n < 8; n++)
				if (socket_raw_ip_setting_in[n] && socket_protocol_number_in[8*n +: 8] == 8'h01)
					icmp = 1'b1;
			go = !blk && !icmp && echo_len_in <= 16'h0077;
			@(negedge ref_clk_in);
			echo_request_in = 1'b0;
			chk("echo_go", {15'h0, go}, {15'h0, echo_reply_go_out});
			chk("echo_drop", {15'h0, !go}, {15'h0, echo_reply_drop_out});
		end
		// mid-run reset onto an 8-bit bus: bus swap ignored, bytes by address
		bus16_strap_in = 1'b0;
		arst_n_in = 1'b0;
		repeat (2) @(negedge ref_clk_in);
		arst_n_in = 1'b1;
		repeat (4) @(negedge ref_clk_in);
		chk("bus8", 16'h0000, {15'h0, bus_width_select_out});
		hw(`HMI_MODE_ADDR + 17'h1, 16'h0005);
		hw(`HMI_PTR_ADDR + 17'h1, 16'h0040);
		hw(`HMI_WIN_ADDR, 16'h00AB);
		hw(`HMI_WIN_ADDR + 17'h1, 16'h00CD);
		chk("byte_wr", 16'hABCD, store[32]);
		hr(`HMI_WIN_ADDR + 17'h1);
		chk("byte_rd", 16'h00CD, q);
		tally_and_finish();
	end
endmodule
